// >>> hw/plt_pkg.sv
// shared constants and types for the link training control block
`default_nettype none
package plt_pkg;
  localparam logic [7:0] PLT_CTRL_OFS = 8'h00;
  localparam logic [7:0] PLT_CFG0_OFS = 8'h04;
  localparam logic [7:0] PLT_CFG1_OFS = 8'h08;
  localparam logic [7:0] PLT_PRE0_OFS = 8'h0C;
  localparam logic [7:0] PLT_PRE1_OFS = 8'h10;
  localparam logic [7:0] PLT_STAT_OFS = 8'h14;
  localparam logic [31:0] PLT_CFG0_RST = 32'h0000_0000;
  localparam logic [31:0] PLT_CFG1_RST = 32'h0000_0000;
  localparam logic [31:0] PLT_PRE0_RST = 32'h0000_0000;
  localparam logic [31:0] PLT_PRE1_RST = 32'h0000_0000;
  localparam logic [31:0] PLT_CFG0_MASK = 32'h0000_7FFF;
  localparam logic [31:0] PLT_CFG1_MASK = 32'h0000_FFFF;
  localparam logic [31:0] PLT_PRE0_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] PLT_PRE1_MASK = 32'h03FF_FFFF;
  localparam int PLT_CTRL_UP_BIT = 0;
  localparam int PLT_CTRL_DOWN_BIT = 1;
  localparam int PLT_CTRL_CLR_BIT = 2;
  localparam logic [2:0] PLT_HINT_RSVD = 3'h7;
  localparam logic [3:0] PLT_CURSOR_CODE = 4'hA;
  localparam logic [5:0] PLT_PRE_DEFAULT = 6'h00;
  localparam logic [5:0] PLT_MAIN_DEFAULT = 6'h3F;
  localparam logic [5:0] PLT_LF_VALUE = 6'h08;
  localparam logic [1:0] PLT_EQ_BYPASS = 2'h0;
  localparam logic [1:0] PLT_EQ_PRESETS = 2'h1;
  localparam logic [1:0] PLT_EQ_FULL = 2'h2;
  localparam logic [1:0] PLT_PROTO_NONE = 2'h0;
  localparam logic [1:0] PLT_PROTO_G34 = 2'h1;
  localparam logic [1:0] PLT_PROTO_G5 = 2'h2;
  localparam logic [1:0] PLT_RATE_2G5 = 2'h0;
  localparam logic [1:0] PLT_RATE_8G = 2'h1;
  localparam logic [1:0] PLT_RATE_16G = 2'h2;
  localparam logic [1:0] PLT_RATE_32G = 2'h3;

  typedef enum logic [10:0] {
    PLT_ST_IDLE = 11'h001,
    PLT_ST_DETECT = 11'h002,
    PLT_ST_POLL = 11'h004,
    PLT_ST_CFG = 11'h008,
    PLT_ST_L0 = 11'h010,
    PLT_ST_SPEED = 11'h020,
    PLT_ST_EQ0 = 11'h040,
    PLT_ST_EQ1 = 11'h080,
    PLT_ST_EQ2 = 11'h100,
    PLT_ST_EQ3 = 11'h200,
    PLT_ST_LPBK = 11'h400
  } plt_state_t;

  // register words decoded into fields
  typedef struct packed {
    logic [1:0] pre1_rsvd; logic main_set; logic pre_set;
    logic [5:0] main_cur; logic [5:0] pre_cur;
    logic [3:0] dut_t5; logic [3:0] dut_t4; logic [3:0] dut_t3;
    logic [3:0] dut_s5; logic [3:0] dut_s4; logic [3:0] dut_s3;
    logic [3:0] tx_g5; logic [3:0] tx_g4; logic [3:0] tx_g3;
    logic [2:0] rx_hint; logic [4:0] lane; logic [7:0] link_num;
    logic pat_mod; logic g5_sel_ltssm; logic g4_sel_ltssm; logic role_up;
    logic [1:0] eq_mode; logic refclk_sep; logic compl_rx;
    logic [3:0] trig_state; logic tgt_cfg; logic [1:0] tgt_speed;
  } plt_cfg_t;

  typedef struct packed {
    logic valid;
    logic cursor;
    logic [3:0] preset;
    logic [5:0] pre;
    logic [5:0] main;
  } plt_req_t;
endpackage
`default_nettype wire

// >>> hw/plt_eq_req.sv
// equalization request toward the partner in phase 2 or 3
`timescale 1ns/10ps
`default_nettype none
module plt_eq_req
  import plt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire plt_cfg_t cfg,
  input wire logic [1:0] rate,
  input wire logic in_p2,
  input wire logic in_p3,
  output plt_req_t req
);
  wire logic [3:0] tgt_preset;
  wire logic req_phase;
  wire logic want_cursor;
  plt_req_t req_d;

  assign tgt_preset = (rate == PLT_RATE_32G) ? cfg.dut_t5 :
                      (rate == PLT_RATE_16G) ? cfg.dut_t4 : cfg.dut_t3;
  // upstream role asks in phase 2, downstream role in phase 3
  assign req_phase = cfg.role_up ? in_p2 : in_p3; // [R16]
  assign want_cursor = (tgt_preset == PLT_CURSOR_CODE);

  always_comb begin
    req_d.cursor = want_cursor;
    req_d.preset = want_cursor ? 4'h0 : tgt_preset;
    // cursor asks only under full equalization
    req_d.valid = req_phase && (!want_cursor || cfg.eq_mode == PLT_EQ_FULL); // [R11] [R16]
    req_d.pre = cfg.pre_set ? cfg.pre_cur : PLT_PRE_DEFAULT; // [R17]
    req_d.main = cfg.main_set ? cfg.main_cur : PLT_MAIN_DEFAULT; // [R18]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req <= '0;
    end else begin
      req <= req_d;
    end
  end
endmodule // plt_eq_req
`default_nettype wire

// >>> hw/plt_top.sv
// link training control: register slave, training sequencer and outputs
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: generation follows selected protocol setting only
// R2: generation 3/4 accepts lane 0 only
// R3: generation 5 accepts lanes 0 to 31
// R4: 16G start preset: user or 8G result
// R5: 32G start preset: user or 16G result
// R6: role setting picks upstream or downstream behaviour
// R7: train toward 8, 16 or 32 GT/s
// R8: reach loopback via L0 or configuration
// R9: trigger high while in selected state
// R10: TS1 compliance receive bit from setting
// R11: bypass stops after phase 1; presets/full acceptance
// R12: link number 0-255 used in its role
// R13: upstream transmitter switches to rate start preset
// R14: upstream sends receiver hint in phase 0
// R15: upstream sends partner start preset in phase 0
// R16: request partner preset or cursors, phase 2/3
// R17: pre-cursor request, default 0
// R18: main-cursor request, default 63
// R19: no scrambling; idle exit symbols from generation
// R20: common or separate reference clock selectable
// R21: protocol channel puts de-emphasis in preset mode
// R22: report low frequency level of 8
// R23: loopback sends compliance or modified compliance
// R24: settings held from training start until end
module plt_top
  import plt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] phy_proto,
  input wire logic link_step,
  input wire logic [3:0] eq_result,
  input wire logic partner_req,
  input wire logic partner_req_cursor,
  output logic [10:0] ltssm_state,
  output logic [1:0] link_rate,
  output logic trigger_control_output,
  output logic ts1_compliance_rx,
  output logic [4:0] lane_num,
  output logic [7:0] link_num,
  output logic link_num_en,
  output logic [3:0] tx_preset,
  output logic [2:0] rx_hint,
  output logic [3:0] dut_start_preset,
  output logic phase0_send,
  output plt_req_t eq_req,
  output logic partner_req_ack,
  output logic partner_req_nak,
  output logic scramble_en,
  output logic eieos_gen5,
  output logic [5:0] low_frequency_level,
  output logic pattern_en,
  output logic pattern_mod,
  output logic deemph_preset_mode,
  output logic refclk_sep
);
  logic [31:0] cfg0_q, cfg1_q, pre0_q, pre1_q;
  plt_cfg_t run_q;
  plt_state_t st_q, st_d;
  logic [1:0] rate_q, rate_d;
  logic [3:0] res_g3_q, res_g4_q;
  logic lane_rej_q;

  // bus decode
  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pwrite;
  wire logic hit_ctrl = (paddr == PLT_CTRL_OFS);
  wire logic hit_cfg0 = (paddr == PLT_CFG0_OFS);
  wire logic hit_cfg1 = (paddr == PLT_CFG1_OFS);
  wire logic hit_pre0 = (paddr == PLT_PRE0_OFS);
  wire logic hit_pre1 = (paddr == PLT_PRE1_OFS);
  wire logic hit_stat = (paddr == PLT_STAT_OFS);
  wire logic mapped = hit_ctrl | hit_cfg0 | hit_cfg1 | hit_pre0 | hit_pre1 | hit_stat;
  wire logic wr_ctrl = wr_en && hit_ctrl;
  wire logic cmd_up = wr_ctrl && pwdata[PLT_CTRL_UP_BIT];
  wire logic cmd_down = wr_ctrl && pwdata[PLT_CTRL_DOWN_BIT];
  wire logic lane_clr = wr_ctrl && pwdata[PLT_CTRL_CLR_BIT];

  // generation comes only from the protocol selection
  wire logic pcie_on = (phy_proto != PLT_PROTO_NONE); // [R1]
  wire logic gen5 = (phy_proto == PLT_PROTO_G5); // [R1]
  wire logic [4:0] lane_wr = pwdata[12:8];
  wire logic lane_ok = gen5 || (lane_wr == 5'h00); // [R2] [R3]
  wire logic hint_ok = (pwdata[15:13] != PLT_HINT_RSVD); // [R14]
  wire logic lane_bad = wr_en && hit_cfg1 && !lane_ok;
  wire logic [31:0] cfg1_wr = {16'h0000, hint_ok ? pwdata[15:13] : cfg1_q[15:13],
                               lane_ok ? lane_wr : cfg1_q[12:8], pwdata[7:0]};

  wire logic [31:0] stat_word = {8'h00, res_g4_q, res_g3_q, gen5, lane_rej_q,
                                 trigger_control_output, rate_q, 11'(st_q)};
  wire logic [31:0] rd_word = hit_cfg0 ? cfg0_q : hit_cfg1 ? cfg1_q :
                              hit_pre0 ? pre0_q : hit_pre1 ? pre1_q :
                              hit_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg0_q <= PLT_CFG0_RST;
      cfg1_q <= PLT_CFG1_RST;
      pre0_q <= PLT_PRE0_RST;
      pre1_q <= PLT_PRE1_RST;
    end else if (wr_en) begin
      if (hit_cfg0) cfg0_q <= pwdata & PLT_CFG0_MASK;
      if (hit_cfg1) cfg1_q <= cfg1_wr; // [R2] [R3] [R12] [R14]
      if (hit_pre0) pre0_q <= pwdata & PLT_PRE0_MASK;
      if (hit_pre1) pre1_q <= pwdata & PLT_PRE1_MASK;
    end
  end

  // a rejected lane write is sticky; a new rejection beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_rej_q <= 1'b0;
    end else begin
      lane_rej_q <= lane_bad || (lane_rej_q && !lane_clr);
    end
  end

  // settings frozen while training runs
  wire logic start = cmd_up && pcie_on && (st_q == PLT_ST_IDLE);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '0;
    end else if (start) begin
      run_q <= plt_cfg_t'({2'h0, pre1_q[25:0], pre0_q[23:0], cfg1_q[15:0], cfg0_q[14:0]}); // [R24]
    end
  end

  // target rate, clamped to what the generation can reach
  wire logic [1:0] tgt_raw = 2'(run_q.tgt_speed + 2'h1); // [R7]
  wire logic [1:0] tgt_rate = (!gen5 && tgt_raw == PLT_RATE_32G) ? PLT_RATE_16G : tgt_raw; // [R1] [R7]
  wire logic at_tgt = (rate_q >= tgt_rate);
  wire logic bypass = (run_q.eq_mode == PLT_EQ_BYPASS);
  wire logic [1:0] rate_up = 2'(rate_q + 2'h1);
  wire plt_state_t eq_done = (at_tgt && run_q.tgt_cfg) ? PLT_ST_CFG : PLT_ST_L0;

  always_comb begin
    st_d = st_q;
    rate_d = rate_q;
    if (cmd_down) begin
      st_d = PLT_ST_IDLE;
      rate_d = PLT_RATE_2G5;
    end else if (start) begin
      st_d = PLT_ST_DETECT;
    end else if (link_step) begin
      case (st_q)
        PLT_ST_DETECT: st_d = PLT_ST_POLL;
        PLT_ST_POLL: st_d = PLT_ST_CFG;
        PLT_ST_CFG: st_d = at_tgt ? PLT_ST_LPBK : PLT_ST_L0; // [R8]
        PLT_ST_L0: st_d = at_tgt ? PLT_ST_LPBK : PLT_ST_SPEED; // [R8]
        PLT_ST_SPEED: begin
          st_d = PLT_ST_EQ0;
          rate_d = rate_up; // [R7]
        end
        PLT_ST_EQ0: st_d = PLT_ST_EQ1;
        PLT_ST_EQ1: st_d = bypass ? eq_done : PLT_ST_EQ2; // [R11]
        PLT_ST_EQ2: st_d = PLT_ST_EQ3;
        PLT_ST_EQ3: st_d = eq_done;
        PLT_ST_IDLE: st_d = PLT_ST_IDLE;
        PLT_ST_LPBK: st_d = PLT_ST_LPBK;
        default: st_d = PLT_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= PLT_ST_IDLE;
      rate_q <= PLT_RATE_2G5;
    end else begin
      st_q <= st_d;
      rate_q <= rate_d;
    end
  end

  // phase 2 outcome kept as the next rate's start preset
  wire logic p2_exit = (st_q == PLT_ST_EQ2) && link_step && !cmd_down;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_g3_q <= 4'h0;
      res_g4_q <= 4'h0;
    end else if (p2_exit) begin
      if (rate_q == PLT_RATE_8G) res_g3_q <= eq_result; // [R4]
      if (rate_q == PLT_RATE_16G) res_g4_q <= eq_result; // [R5]
    end
  end

  wire logic [3:0] start_g4 = run_q.g4_sel_ltssm ? res_g3_q : run_q.tx_g4; // [R4]
  wire logic [3:0] start_g5 = run_q.g5_sel_ltssm ? res_g4_q : run_q.tx_g5; // [R5]
  wire logic [3:0] start_new = (rate_d == PLT_RATE_32G) ? start_g5 :
                               (rate_d == PLT_RATE_16G) ? start_g4 : run_q.tx_g3;
  wire logic speed_in = (st_q == PLT_ST_SPEED) && (st_d == PLT_ST_EQ0);
  wire logic [3:0] dut_start = (rate_q == PLT_RATE_32G) ? run_q.dut_s5 :
                               (rate_q == PLT_RATE_16G) ? run_q.dut_s4 : run_q.dut_s3;
  wire logic in_eq0 = (st_q == PLT_ST_EQ0);
  wire logic ph0_up = in_eq0 && run_q.role_up; // [R6] [R14] [R15]
  wire logic run_on = (st_q != PLT_ST_IDLE);
  // cursor asks from the partner accepted only under full equalization
  wire logic req_take = partner_req && (st_q == PLT_ST_EQ2 || st_q == PLT_ST_EQ3) &&
                        (!partner_req_cursor || run_q.eq_mode == PLT_EQ_FULL); // [R11]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_preset <= 4'h0;
      rx_hint <= 3'h0;
      dut_start_preset <= 4'h0;
      phase0_send <= 1'b0;
      partner_req_ack <= 1'b0;
      partner_req_nak <= 1'b0;
    end else begin
      if (speed_in && run_q.role_up) tx_preset <= start_new; // [R13]
      rx_hint <= ph0_up ? run_q.rx_hint : 3'h0; // [R14]
      dut_start_preset <= ph0_up ? dut_start : 4'h0; // [R15]
      phase0_send <= ph0_up; // [R14] [R15]
      partner_req_ack <= req_take; // [R11]
      partner_req_nak <= partner_req && !req_take; // [R11]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ltssm_state <= 11'(PLT_ST_IDLE);
      link_rate <= PLT_RATE_2G5;
      trigger_control_output <= 1'b0;
      ts1_compliance_rx <= 1'b0;
      lane_num <= 5'h00;
      link_num <= 8'h00;
      link_num_en <= 1'b0;
      scramble_en <= 1'b0;
      eieos_gen5 <= 1'b0;
      low_frequency_level <= PLT_LF_VALUE;
      pattern_en <= 1'b0;
      pattern_mod <= 1'b0;
      deemph_preset_mode <= 1'b0;
      refclk_sep <= 1'b0;
    end else begin
      ltssm_state <= 11'(st_q);
      link_rate <= rate_q;
      trigger_control_output <= run_on && (11'(st_q) == (11'h001 << run_q.trig_state)); // [R9]
      ts1_compliance_rx <= run_on && run_q.compl_rx; // [R10]
      lane_num <= run_q.lane; // [R2] [R3]
      link_num <= run_q.link_num; // [R12]
      link_num_en <= run_on && run_q.role_up; // [R6] [R12]
      scramble_en <= 1'b0; // [R19]
      eieos_gen5 <= gen5; // [R19]
      low_frequency_level <= PLT_LF_VALUE; // [R22]
      pattern_en <= (st_q == PLT_ST_LPBK); // [R23]
      pattern_mod <= run_q.pat_mod; // [R23]
      deemph_preset_mode <= pcie_on; // [R21]
      refclk_sep <= run_q.refclk_sep; // [R20]
    end
  end

  plt_eq_req u_eq_req (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(run_q),
    .rate(rate_q),
    .in_p2(st_q == PLT_ST_EQ2),
    .in_p3(st_q == PLT_ST_EQ3),
    .req(eq_req)
  );

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_eq0_up;
    (st_q == PLT_ST_EQ0) && run_q.role_up;
  endsequence

  a_trig_follows_state: assert property ( // [R9]
    ##1 trigger_control_output == $past(run_on && ((11'(st_q) >> run_q.trig_state) == 11'h001)))
    else $error("trigger does not track state");
  a_lane_gen34_zero: assert property ( // [R2]
    (wr_en && hit_cfg1 && !gen5 && lane_wr != 5'h00) |=> cfg1_q[12:8] == $past(cfg1_q[12:8]) && lane_rej_q)
    else $error("nonzero lane taken in gen3/4");
  a_hint_in_phase0: assert property ( // [R14]
    s_eq0_up |=> phase0_send && rx_hint == $past(run_q.rx_hint))
    else $error("hint not sent in phase 0");
  a_req_role_phase: assert property ( // [R16]
    (st_q == PLT_ST_EQ2 && !run_q.role_up) |=> !eq_req.valid)
    else $error("downstream role asked in phase 2");
  a_bypass_skips_p2: assert property ( // [R11]
    (st_q == PLT_ST_EQ1 && bypass && link_step && !cmd_down) |=> st_q != PLT_ST_EQ2)
    else $error("bypass entered phase 2");
  a_cursor_default: assert property ( // [R18]
    (st_q == PLT_ST_EQ2 && run_q.role_up && !run_q.main_set) |=> eq_req.main == PLT_MAIN_DEFAULT)
    else $error("main cursor default wrong");
  a_cfg_frozen: assert property ( // [R24]
    (run_on && !start) |=> $stable(run_q))
    else $error("settings changed during training");
  a_lf_fixed: assert property ( // [R22]
    ##1 low_frequency_level == PLT_LF_VALUE)
    else $error("low frequency level not 8");
  a_down_to_idle: assert property ( // [R8]
    cmd_down |=> st_q == PLT_ST_IDLE ##1 ltssm_state == 11'(PLT_ST_IDLE))
    else $error("down did not reach idle");
  a_rate_limit: assert property ( // [R7]
    st_q == PLT_ST_LPBK |-> rate_q == tgt_rate)
    else $error("loopback at wrong rate");
endmodule // plt_top
`default_nettype wire

// >>> dv/plt_partner.sv
// far-end device model: paces training steps, reports phase 2 preset, applies requests
`timescale 1ns/10ps
`default_nettype none
module plt_partner
  import plt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step_go,
  input wire logic slow,
  input wire logic req_go,
  input wire logic req_cur,
  input wire logic [3:0] eq_val,
  input wire plt_req_t eq_req,
  input wire logic [10:0] ltssm_state,
  input wire logic partner_req_ack,
  input wire logic partner_req_nak,
  output logic link_step,
  output logic [3:0] eq_result,
  output logic partner_req,
  output logic partner_req_cursor,
  output plt_req_t applied_q,
  output logic [10:0] applied_st_q,
  output logic [1:0] answer_q
);
  logic [2:0] wait_q;
  // result only meaningful in phase 2; elsewhere a wrong value
  assign eq_result = ltssm_state[8] ? eq_val : ~eq_val;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 3'h0;
      link_step <= 1'b0;
      partner_req <= 1'b0;
      partner_req_cursor <= 1'b0;
      answer_q <= 2'h0;
    end else begin
      if (step_go) wait_q <= slow ? 3'h5 : 3'h1;
      else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
      link_step <= (wait_q == 3'h1);
      partner_req <= req_go;
      partner_req_cursor <= req_cur;
      if (req_go) answer_q <= 2'h0;
      else if (partner_req_ack) answer_q <= 2'h1;
      else if (partner_req_nak) answer_q <= 2'h2;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      applied_q <= '0;
      applied_st_q <= 11'h000;
    end else if (eq_req.valid) begin
      applied_q.valid <= 1'b1;
      applied_q.cursor <= eq_req.cursor;
      applied_q.preset <= eq_req.cursor ? 4'h0 : eq_req.preset;
      applied_q.pre <= eq_req.cursor ? eq_req.pre : 6'h00;
      applied_q.main <= eq_req.cursor ? eq_req.main : 6'h00;
      applied_st_q <= ltssm_state;
    end
  end
endmodule // plt_partner
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the link training control block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import plt_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_step, partner_req, partner_req_cursor;
  logic trigger_control_output, ts1_compliance_rx, link_num_en, phase0_send, partner_req_ack;
  logic partner_req_nak, scramble_en, eieos_gen5, pattern_en, pattern_mod, deemph_preset_mode;
  logic refclk_sep, step_go, slow, req_go, req_cur, mon_on, err, x_role, x_cur;
  logic [1:0] phy_proto, link_rate, answer_q;
  logic [2:0] rx_hint, x_hint;
  logic [3:0] eq_result, tx_preset, dut_start_preset, eq_val;
  logic [3:0] x_ds [1:2];
  logic [3:0] x_tx [1:2];
  logic [4:0] lane_num;
  logic [5:0] low_frequency_level;
  logic [7:0] paddr, link_num;
  logic [10:0] ltssm_state, applied_st_q, x_st;
  logic [31:0] pwdata, prdata, rd, lr, v;
  plt_req_t eq_req, applied_q, x_req;
  int num_errors, check_count, seed, k, x_trig;
  logic [7:0] ofs [3] = '{PLT_CFG0_OFS, PLT_PRE0_OFS, PLT_PRE1_OFS};
  logic [31:0] msk [3] = '{PLT_CFG0_MASK, PLT_PRE0_MASK, PLT_PRE1_MASK};

  plt_top plt_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .phy_proto, .link_step, .eq_result, .partner_req, .partner_req_cursor, .ltssm_state,
    .link_rate, .trigger_control_output, .ts1_compliance_rx, .lane_num, .link_num, .link_num_en,
    .tx_preset, .rx_hint, .dut_start_preset, .phase0_send, .eq_req, .partner_req_ack, .partner_req_nak,
    .scramble_en, .eieos_gen5, .low_frequency_level, .pattern_en, .pattern_mod, .deemph_preset_mode,
    .refclk_sep);
  plt_partner plt_partner_inst (.pclk, .presetn, .step_go, .slow, .req_go, .req_cur, .eq_val, .eq_req,
    .ltssm_state, .partner_req_ack, .partner_req_nak, .link_step, .eq_result, .partner_req,
    .partner_req_cursor, .applied_q, .applied_st_q, .answer_q);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [31:0] exp_cfg1(input logic [31:0] o, input logic [31:0] n, input logic [1:0] pr);
    exp_cfg1 = n & PLT_CFG1_MASK;
    if (pr != PLT_PROTO_G5) exp_cfg1[12:8] = o[12:8];
    if (n[15:13] == PLT_HINT_RSVD) exp_cfg1[15:13] = o[15:13];
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic go_to(input int idx);
    int n;
    n = 0;
    if (idx > 1) begin
      step_go <= 1'b1;
      @(posedge pclk);
      step_go <= 1'b0;
    end
    while (ltssm_state !== (11'h001 << idx) && n < 24) begin
      @(posedge pclk);
      n++;
    end
    chk(ltssm_state, 32'h1 << idx, "state");
    repeat (2) @(posedge pclk);
  endtask

  task automatic run(input logic [1:0] pr, input logic [31:0] c0, input logic [31:0] c1,
    input logic [31:0] p0, input logic [31:0] p1, input int seq[$]);
    do_reset;
    phy_proto <= pr;
    apb(1'b1, PLT_CFG0_OFS, c0);
    apb(1'b1, PLT_CFG1_OFS, c1);
    apb(1'b1, PLT_PRE0_OFS, p0);
    apb(1'b1, PLT_PRE1_OFS, p1);
    apb(1'b1, PLT_CTRL_OFS, 32'h0000_0001);
    x_trig = int'(c0[6:3]);
    mon_on = 1'b1;
    k = 0;
    foreach (seq[i]) begin
      go_to(seq[i]);
      if (seq[i] == 6) begin
        k++;
        chk(link_rate, k, "rate");
        chk(phase0_send, x_role, "phase0 send");
        chk(rx_hint, x_role ? x_hint : 3'h0, "hint");
        chk(dut_start_preset, x_role ? x_ds[k] : 4'h0, "dut start");
        if (x_role) chk(tx_preset, x_tx[k], "tx start");
      end
      if (seq[i] == 7) apb(1'b1, PLT_CFG0_OFS, c0 ^ 32'h0000_0180);
      if (seq[i] == 8) begin
        req_cur <= x_cur;
        req_go <= 1'b1;
        @(posedge pclk);
        req_go <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(answer_q, (x_cur && c0[10:9] != PLT_EQ_FULL) ? 2'h2 : 2'h1, "answer");
      end
    end
    chk(pattern_en, 1'b1, "pattern on");
    chk(pattern_mod, c0[14], "pattern kind");
    chk(ts1_compliance_rx, c0[7], "compliance bit");
    chk(refclk_sep, c0[8], "refclk");
    chk(link_num_en, c0[11], "link enable");
    chk(link_num, c1[7:0], "link number");
    chk(lane_num, pr == PLT_PROTO_G5 ? c1[12:8] : 5'h00, "lane");
    chk(applied_q, x_req, "request");
    chk(applied_st_q, x_st, "request phase");
    chk(deemph_preset_mode, pr != PLT_PROTO_NONE, "deemph");
    chk(eieos_gen5, pr == PLT_PROTO_G5, "eieos");
    chk(scramble_en, 1'b0, "scramble");
    chk(low_frequency_level, PLT_LF_VALUE, "lf level");
    apb(1'b1, PLT_CTRL_OFS, 32'h0000_0002);
    mon_on = 1'b0;
    go_to(0);
    chk(link_rate, 2'h0, "rate down");
  endtask

  always @(negedge pclk) begin
    if (mon_on && presetn && ltssm_state !== 11'h001) chk(trigger_control_output, ltssm_state[x_trig], "trig");
  end

  initial begin
    seed = 71057;
    num_errors = 0;
    check_count = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, step_go, slow, req_go, req_cur, mon_on} = 8'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    phy_proto = PLT_PROTO_NONE;
    eq_val = 4'h3;
    do_reset;
    chk(low_frequency_level, PLT_LF_VALUE, "lf reset");
    apb(1'b1, PLT_CTRL_OFS, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    chk(ltssm_state, 32'h1, "up refused");
    apb(1'b0, 8'h18, 32'h0);
    chk(err, 1'b1, "unmapped error");
    chk(rd, 32'h0000_0000, "unmapped data");
    for (int i = 0; i < 9; i++) begin
      v = $random(seed);
      apb(1'b1, ofs[i % 3], v);
      apb(1'b0, ofs[i % 3], 32'h0);
      chk(rd, v & msk[i % 3], "readback");
    end
    phy_proto <= PLT_PROTO_G34;
    apb(1'b1, PLT_CFG1_OFS, 32'h0000_4011);
    apb(1'b1, PLT_CFG1_OFS, 32'h0000_E5AA);
    apb(1'b0, PLT_CFG1_OFS, 32'h0);
    chk(rd, exp_cfg1(32'h4011, 32'hE5AA, PLT_PROTO_G34), "lane refused");
    apb(1'b0, PLT_STAT_OFS, 32'h0);
    chk(rd[14], 1'b1, "lane flag");
    apb(1'b1, PLT_CTRL_OFS, 32'h0000_0004);
    apb(1'b0, PLT_STAT_OFS, 32'h0);
    chk(rd[14], 1'b0, "lane flag clear");
    phy_proto <= PLT_PROTO_G5;
    apb(1'b1, PLT_CFG1_OFS, 32'h0000_DF33);
    apb(1'b0, PLT_CFG1_OFS, 32'h0);
    chk(rd, exp_cfg1(32'h40AA, 32'hDF33, PLT_PROTO_G5), "lane 31");
    $display("test registers done");
    lr = $random(seed);
    x_role = 1'b1;
    x_hint = 3'h3;
    x_ds[1] = 4'h7;
    x_tx[1] = 4'h5;
    x_cur = 1'b1;
    x_req = '{1'b1, 1'b0, 4'h2, 6'h00, 6'h00};
    x_st = 11'h100;
    run(PLT_PROTO_G34, 32'h0BA0, {16'h0, 8'h60, lr[7:0]}, 32'h7005, 32'h2, '{1, 2, 3, 4, 5, 6, 7, 8, 9, 4, 10});
    $display("test upstream presets done");
    lr = $random(seed);
    slow <= 1'b1;
    eq_val <= 4'h6;
    x_hint = 3'h6;
    x_ds[1] = 4'h4;
    x_ds[2] = 4'h8;
    x_tx[1] = 4'h1;
    x_tx[2] = 4'h6;
    x_req = '{1'b1, 1'b1, 4'h0, lr[13:8], 6'h3F};
    run(PLT_PROTO_G5, 32'h1C55, {16'h0, 8'hDF, lr[7:0]}, 32'h84091, {8'h01, 6'h00, lr[13:8], 12'h0AA},
      '{1, 2, 3, 4, 5, 6, 7, 8, 9, 4, 5, 6, 7, 8, 9, 3, 10});
    $display("test upstream cursor done");
    lr = $random(seed);
    slow <= 1'b0;
    x_role = 1'b0;
    x_req = '0;
    x_st = 11'h000;
    run(PLT_PROTO_G34, 32'h4038, {16'h0, 8'hE5, lr[7:0]}, 32'h1234, 32'h3, '{1, 2, 3, 4, 5, 6, 7, 4, 10});
    $display("test downstream bypass done");
    wrap_up;
  end

  initial begin
    #2000000;
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule // testbench
`default_nettype wire
